// file: lsc_pkg.sv
// Constants shared by the link status and control block
package lsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] LSC_OFF_CONFIG = 12'h060;
    localparam logic [11:0] LSC_OFF_LINK = 12'h064;
    localparam logic [11:0] LSC_OFF_CAPS = 12'h070;

    ////////////////////////////////////////////////////////////////////////////////
    // Link status and control field positions
    localparam int LSC_B_ATTACHED = 0;
    localparam int LSC_B_CHANGE = 1;
    localparam int LSC_B_ENABLED = 2;
    localparam int LSC_B_RESUME = 6;
    localparam int LSC_B_ASLEEP = 7;
    localparam int LSC_B_RESET = 8;
    localparam int LSC_B_DM = 10;
    localparam int LSC_B_DP = 11;
    localparam int LSC_B_POWER = 12;
    localparam int LSC_B_HANDOFF = 13;
    localparam int LSC_B_PIC_LO = 14;
    localparam int LSC_B_TMS_LO = 16;
    localparam int LSC_PIC_W = 2;
    localparam int LSC_TMS_W = 4;

    // Configured flag and capability field positions
    localparam int LSC_B_CF = 0;
    localparam int LSC_B_PPC = 0;
    localparam int LSC_B_PIND = 1;
    localparam int LSC_B_SETTLED = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic LSC_HANDOFF_RST = 1'b1;
    localparam logic LSC_PPC_RST = 1'b1;
    localparam logic LSC_PIND_RST = 1'b0;
    localparam logic [3:0] LSC_TMS_RST = 4'h0;
    localparam logic [1:0] LSC_PIC_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint LSC_CLK_HZ = 125000000;
    localparam longint LSC_POWER_SETTLE_MS = 20;
    localparam longint LSC_POWER_SETTLE_CYC = (LSC_CLK_HZ * LSC_POWER_SETTLE_MS + 999) / 1000;
    localparam int LSC_SYNC_W = 5;

endpackage

// file: lsc_sync.sv
// Two flip-flop synchroniser for the link pin inputs
`timescale 1ns/1ps
module lsc_sync #(
    parameter int WIDTH = 5
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } lsc_sync_state_t;

    lsc_sync_state_t st_r;
    lsc_sync_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: first stage feeds only the second
    always_comb begin
        st_nxt = st_r;
        st_nxt.first = async_in;
        st_nxt.second = st_r.first;
    end

    // State register, frozen while ce is low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.second;

endmodule // lsc_sync

// file: lsc_link_ctrl.sv
// Root link status and control register with APB slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module lsc_link_ctrl #(
    parameter int POWER_SETTLE_CYCLES = int'(lsc_pkg::LSC_POWER_SETTLE_CYC)
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic hc_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pin_attach,
    input wire logic pin_dp,
    input wire logic pin_dm,
    input wire logic pin_k_state,
    input wire logic pin_reset_busy,
    output logic link_power_en,
    output logic link_enable,
    output logic link_suspend,
    output logic link_resume_drive,
    output logic [3:0] test_mode,
    output logic test_mode_active,
    output logic [1:0] indicator_led,
    output logic companion_owned,
    output logic power_settled
);

    localparam int SETTLE_W = $clog2(POWER_SETTLE_CYCLES + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(POWER_SETTLE_CYCLES - 1);

    typedef struct packed {
        logic cf;
        logic power_switch_capability;
        logic pind;
        logic power;
        logic handoff;
        logic [1:0] indicator_led_control;
        logic [3:0] tms;
        logic asleep;
        logic resume;
        logic enabled;
        logic change;
        logic attached;
        logic rst_seen;
        logic [SETTLE_W-1:0] settle;
        logic settled;
        logic [31:0] rdata;
        logic slverr;
    } lsc_state_t;

    lsc_state_t st_r;
    lsc_state_t st_nxt;
    logic [4:0] pins_s;
    logic att_s;
    logic dp_s;
    logic dm_s;
    logic k_s;
    logic rst_s;
    logic wr;
    logic setup;
    logic hit_cfg;
    logic hit_link;
    logic hit_caps;
    logic power_eff;
    logic locked;
    logic [31:0] link_word;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    lsc_sync #(
        .WIDTH(lsc_pkg::LSC_SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .async_in({pin_reset_busy, pin_k_state, pin_dm, pin_dp, pin_attach}),
        .sync_out(pins_s)
    );

    assign att_s = pins_s[0];
    assign dp_s = pins_s[1];
    assign dm_s = pins_s[2];
    assign k_s = pins_s[3];
    assign rst_s = pins_s[4];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && ce;
    assign hit_cfg = (paddr == lsc_pkg::LSC_OFF_CONFIG);
    assign hit_link = (paddr == lsc_pkg::LSC_OFF_LINK);
    assign hit_caps = (paddr == lsc_pkg::LSC_OFF_CAPS);

    // Effective power and write lock
    assign power_eff = st_r.power_switch_capability ? st_r.power : 1'b1;
    assign locked = st_r.power_switch_capability && !st_r.power;

    ////////////////////////////////////////////////////////////////////////////////
    // Link word as read by software
    always_comb begin
        link_word = 32'h0000_0000;
        link_word[lsc_pkg::LSC_B_TMS_LO +: lsc_pkg::LSC_TMS_W] = st_r.tms;
        link_word[lsc_pkg::LSC_B_HANDOFF] = st_r.handoff;
        link_word[lsc_pkg::LSC_B_POWER] = power_eff;
        link_word[lsc_pkg::LSC_B_DP] = dp_s;
        link_word[lsc_pkg::LSC_B_DM] = dm_s;
        link_word[lsc_pkg::LSC_B_RESUME] = st_r.resume || (k_s && st_r.asleep);
        link_word[lsc_pkg::LSC_B_ENABLED] = st_r.enabled;
        if (power_eff) begin
            link_word[lsc_pkg::LSC_B_PIC_LO +: lsc_pkg::LSC_PIC_W] = st_r.indicator_led_control;
            link_word[lsc_pkg::LSC_B_RESET] = rst_s;
            link_word[lsc_pkg::LSC_B_ASLEEP] = st_r.asleep;
            link_word[lsc_pkg::LSC_B_CHANGE] = st_r.change;
            link_word[lsc_pkg::LSC_B_ATTACHED] = st_r.attached;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_cfg) begin
            rd_word[lsc_pkg::LSC_B_CF] = st_r.cf;
        end
        if (hit_link) begin
            rd_word = link_word;
        end
        if (hit_caps) begin
            rd_word[lsc_pkg::LSC_B_PPC] = st_r.power_switch_capability;
            rd_word[lsc_pkg::LSC_B_PIND] = st_r.pind;
            rd_word[lsc_pkg::LSC_B_SETTLED] = st_r.settled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Configuration and capability writes
        if (wr && hit_cfg) begin
            st_nxt.cf = pwdata[lsc_pkg::LSC_B_CF];
        end
        if (wr && hit_caps) begin
            st_nxt.power_switch_capability = pwdata[lsc_pkg::LSC_B_PPC];
            st_nxt.pind = pwdata[lsc_pkg::LSC_B_PIND];
        end
        // Link register writes
        if (wr && hit_link) begin
            if (st_r.power_switch_capability) begin
                st_nxt.power = pwdata[lsc_pkg::LSC_B_POWER];
            end
            if (st_r.pind) begin
                st_nxt.indicator_led_control = pwdata[lsc_pkg::LSC_B_PIC_LO +: lsc_pkg::LSC_PIC_W];
            end
            st_nxt.handoff = pwdata[lsc_pkg::LSC_B_HANDOFF];
            if (!locked) begin
                st_nxt.tms = pwdata[lsc_pkg::LSC_B_TMS_LO +: lsc_pkg::LSC_TMS_W];
                st_nxt.asleep = pwdata[lsc_pkg::LSC_B_ASLEEP];
                st_nxt.resume = pwdata[lsc_pkg::LSC_B_RESUME];
                if (!pwdata[lsc_pkg::LSC_B_ENABLED]) begin
                    st_nxt.enabled = 1'b0;
                end
                if (st_r.resume && !pwdata[lsc_pkg::LSC_B_RESUME]) begin
                    st_nxt.asleep = 1'b0;
                end
            end
            if (pwdata[lsc_pkg::LSC_B_CHANGE]) begin
                st_nxt.change = 1'b0;
            end
        end
        // Attach tracking; a change beats a same-cycle clear
        st_nxt.attached = att_s;
        if (att_s != st_r.attached) begin
            st_nxt.change = 1'b1;
        end
        if (!att_s) begin
            st_nxt.enabled = 1'b0;
        end
        // Enable at the end of a link reset with a peripheral present
        st_nxt.rst_seen = rst_s;
        if (st_r.rst_seen && !rst_s && att_s) begin
            st_nxt.enabled = 1'b1;
        end
        // Remote wake K-state while asleep latches resume
        if (k_s && st_r.asleep) begin
            st_nxt.resume = 1'b1;
        end
        // Companion ownership follows the configured flag
        if (!st_nxt.cf) begin
            st_nxt.handoff = 1'b1;
        end else if (!st_r.cf) begin
            st_nxt.handoff = 1'b0;
        end
        // Power settle timer, restarted on every power bit change
        if (st_r.power_switch_capability && (st_nxt.power != st_r.power)) begin
            st_nxt.settle = '0;
            st_nxt.settled = 1'b0;
        end else if (!st_r.settled) begin
            st_nxt.settle = st_r.settle + SETTLE_W'(1);
            if (st_r.settle == SETTLE_LAST) begin
                st_nxt.settled = 1'b1;
            end
        end
        // Host controller reset returns everything to reset values except read data and error flag captured by a setup in the same cycle
        if (hc_reset) begin
            st_nxt = '0;
            st_nxt.handoff = lsc_pkg::LSC_HANDOFF_RST;
            st_nxt.power_switch_capability = lsc_pkg::LSC_PPC_RST;
            st_nxt.pind = lsc_pkg::LSC_PIND_RST;
            st_nxt.attached = 1'b0;
            st_nxt.enabled = 1'b0;
        end
        // Read data captured in the setup cycle
        if (setup) begin
            st_nxt.rdata = rd_word;
            st_nxt.slverr = !(hit_cfg || hit_link || hit_caps);
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.handoff <= lsc_pkg::LSC_HANDOFF_RST;
            st_r.power_switch_capability <= lsc_pkg::LSC_PPC_RST;
            st_r.pind <= lsc_pkg::LSC_PIND_RST;
            st_r.tms <= lsc_pkg::LSC_TMS_RST;
            st_r.indicator_led_control <= lsc_pkg::LSC_PIC_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = st_r.rdata;
    assign pready = ce;
    assign pslverr = psel && penable && st_r.slverr;
    assign link_power_en = power_eff;
    assign link_enable = st_r.enabled;
    assign link_suspend = st_r.asleep;
    assign link_resume_drive = st_r.resume;
    assign test_mode = st_r.tms;
    assign test_mode_active = (st_r.tms != 4'h0);
    assign indicator_led = power_eff ? st_r.indicator_led_control : 2'h0;
    assign companion_owned = st_r.handoff;
    assign power_settled = st_r.settled;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_hc_reset_clear: assert property ((ce && hc_reset) |=>
        (!st_r.attached && !st_r.enabled && st_r.handoff && !st_r.cf))
        else $error("host controller reset left link state set");

    a_handoff_forced: assert property (!st_r.cf |-> st_r.handoff)
        else $error("handoff low while configured flag low");

    a_handoff_rise: assert property ($rose(st_r.cf) |-> !st_r.handoff)
        else $error("handoff not cleared on configured flag rise");

    a_change_sets: assert property ((ce && !hc_reset && (att_s != st_r.attached))
        |=> st_r.change)
        else $error("attach change did not set change flag");

    a_pic_locked: assert property ((ce && !st_r.pind && !hc_reset) |=>
        (st_r.indicator_led_control == $past(st_r.indicator_led_control)))
        else $error("indicator changed without capability");

    a_power_lock: assert property ((ce && locked && !hc_reset && wr && hit_link) |=>
        ((st_r.tms == $past(st_r.tms)) && (st_r.asleep == $past(st_r.asleep))))
        else $error("link state changed while power off");

    a_power_off_zero: assert property (!power_eff |->
        (link_word[lsc_pkg::LSC_B_PIC_LO +: lsc_pkg::LSC_PIC_W] == 2'h0 &&
        link_word[lsc_pkg::LSC_B_RESET] == 1'b0 && link_word[lsc_pkg::LSC_B_ASLEEP] == 1'b0 &&
        link_word[lsc_pkg::LSC_B_CHANGE] == 1'b0 && link_word[lsc_pkg::LSC_B_ATTACHED] == 1'b0))
        else $error("gated fields nonzero with power off");

    a_line_levels: assert property (hit_link |->
        (rd_word[lsc_pkg::LSC_B_DP] == dp_s && rd_word[lsc_pkg::LSC_B_DM] == dm_s))
        else $error("line level bits wrong");

    a_test_active: assert property (test_mode_active == (link_word[19:16] != 4'h0))
        else $error("test mode active mismatch");

    a_read_capture: assert property ((ce && setup) ##1 (psel && penable) |->
        (prdata == $past(rd_word)))
        else $error("read data not captured in setup");

    a_no_power_fixed: assert property (!st_r.power_switch_capability |-> link_power_en)
        else $error("power off without power switching");

    a_detach_disables: assert property ((ce && !hc_reset && !att_s) |=> !st_r.enabled)
        else $error("link left enabled after detach");

    a_change_clear: assert property ((wr && hit_link && pwdata[lsc_pkg::LSC_B_CHANGE] &&
        !hc_reset && (att_s == st_r.attached)) |=> !st_r.change)
        else $error("change flag not cleared by write of one");

    a_resume_latch: assert property ((ce && !hc_reset && k_s && st_r.asleep) |=>
        st_r.resume)
        else $error("remote wake did not latch resume");

    a_reset_bit: assert property ((hit_link && power_eff) |->
        (rd_word[lsc_pkg::LSC_B_RESET] == rst_s))
        else $error("link reset bit does not follow pin");

    a_sleep_bit: assert property ((hit_link && power_eff) |->
        (rd_word[lsc_pkg::LSC_B_ASLEEP] == st_r.asleep))
        else $error("sleep bit does not follow link state");

endmodule // lsc_link_ctrl

// file: lsc_periph.sv
// Attached peripheral model driving the link pins
`timescale 1ns/1ps
module lsc_periph (
    input wire logic attach,
    input wire logic [1:0] lines,
    input wire logic k_req,
    input wire logic rst_busy,
    output logic pin_attach,
    output logic pin_dp,
    output logic pin_dm,
    output logic pin_k_state,
    output logic pin_reset_busy
);
    // Lines fall to the host pull-down level while detached
    assign pin_attach = attach;
    assign pin_dp = attach & lines[1];
    assign pin_dm = attach & lines[0];
    // Resume K-state and reset only with a peripheral present
    assign pin_k_state = attach & k_req;
    assign pin_reset_busy = attach & rst_busy;
endmodule // lsc_periph

// file: lsc_link_ctrl_tb.sv
// Self-checking bench for the link status and control block
`timescale 1ns/1ps
module lsc_link_ctrl_tb;
    localparam logic [11:0] LNK = lsc_pkg::LSC_OFF_LINK;
    localparam logic [11:0] CFG = lsc_pkg::LSC_OFF_CONFIG;
    localparam logic [11:0] CAP = lsc_pkg::LSC_OFF_CAPS;
    logic mclk = 0, reset = 1, ce = 1, hc_reset = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, attach = 0, k_req = 0, rst_busy = 0;
    logic [1:0] lines = 2'h0;
    logic pa, pdp, pdm, pk, prb, pwr_en, l_en, l_link_asleep, l_res, tma, ho_o, settled;
    logic [3:0] tm;
    logic [1:0] led;
    int n_mismatch = 0, comparisons = 0, i;
    int m_pwr, m_tms, m_pic, m_ho, m_att, m_chg, m_en, m_slp, m_res, m_rst, m_dp, m_dm;

    always #4 mclk = ~mclk;

    lsc_periph i_periph (.attach(attach), .lines(lines), .k_req(k_req), .rst_busy(rst_busy),
        .pin_attach(pa), .pin_dp(pdp), .pin_dm(pdm), .pin_k_state(pk), .pin_reset_busy(prb));

    lsc_link_ctrl #(.POWER_SETTLE_CYCLES(16)) i_dut (.mclk(mclk), .reset(reset), .ce(ce),
        .hc_reset(hc_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_attach(pa), .pin_dp(pdp), .pin_dm(pdm), .pin_k_state(pk), .pin_reset_busy(prb),
        .link_power_en(pwr_en), .link_enable(l_en), .link_suspend(l_link_asleep),
        .link_resume_drive(l_res), .test_mode(tm), .test_mode_active(tma),
        .indicator_led(led), .companion_owned(ho_o), .power_settled(settled));

    ////////////////////////////////////////////////////////////////////////////////
    // Counts, verdict and end of run
    task print_verdict();
        $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // APB transfer; pready, data and error taken at the rising edge that ends access
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
        @(posedge mclk);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Expected link word; power-off gating, reserved bits zero for writes too
    function automatic logic [31:0] mw();
        logic p;
        p = m_pwr[0];
        return {12'h0, m_tms[3:0], m_pic[1:0] & {2{p}}, m_ho[0], p, m_dp[0], m_dm[0], 1'b0,
            m_rst[0] & p, m_slp[0] & p, m_res[0], 3'h0, m_en[0], m_chg[0] & p, m_att[0] & p};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(16));
        m_ho = 1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rdc(LNK, mw());
        rdc(CAP, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, LNK, 32'h0005_2084);
        rdc(LNK, mw());
        m_pwr = 1;
        apb(1'b1, LNK, mw());
        chk({31'h0, settled}, 32'h0);
        for (i = 0; i < 100 && settled !== 1'b1; i++) @(posedge mclk);
        chk({31'h0, settled}, 32'h1);
        rdc(CAP, 32'h5);
        chk({31'h0, pwr_en}, 32'h1);
        $display("test power done");
        for (i = 0; i < 16; i++) begin
            m_tms = i;
            apb(1'b1, LNK, mw());
            rdc(LNK, mw());
            chk({27'h0, tma, tm}, {27'h0, i != 0, i[3:0]});
        end
        m_tms = 0;
        apb(1'b1, LNK, mw() | 32'h8000);
        rdc(LNK, mw());
        apb(1'b1, CAP, 32'h3);
        m_pic = 3;
        apb(1'b1, LNK, mw());
        chk({30'h0, led}, 32'h3);
        $display("test fields done");
        m_dp = $urandom % 2;
        m_dm = $urandom % 2;
        lines <= {m_dp[0], m_dm[0]};
        attach <= 1'b1;
        repeat (6) @(posedge mclk);
        m_att = 1;
        m_chg = 1;
        rdc(LNK, mw());
        apb(1'b1, LNK, mw());
        m_chg = 0;
        rdc(LNK, mw());
        rst_busy <= 1'b1;
        repeat (6) @(posedge mclk);
        m_rst = 1;
        rdc(LNK, mw());
        rst_busy <= 1'b0;
        repeat (6) @(posedge mclk);
        m_rst = 0;
        m_en = 1;
        rdc(LNK, mw());
        chk({31'h0, l_en}, 32'h1);
        m_en = 0;
        apb(1'b1, LNK, mw());
        rdc(LNK, mw());
        $display("test attach done");
        m_slp = 1;
        apb(1'b1, LNK, mw());
        rdc(LNK, mw());
        chk({31'h0, l_link_asleep}, 32'h1);
        k_req <= 1'b1;
        repeat (6) @(posedge mclk);
        m_res = 1;
        rdc(LNK, mw());
        chk({31'h0, l_res}, 32'h1);
        k_req <= 1'b0;
        repeat (6) @(posedge mclk);
        m_res = 0;
        m_slp = 0;
        apb(1'b1, LNK, mw());
        rdc(LNK, mw());
        $display("test sleep done");
        apb(1'b1, CFG, 32'h1);
        m_ho = 0;
        rdc(LNK, mw());
        apb(1'b1, CFG, 32'h0);
        m_ho = 1;
        rdc(LNK, mw());
        apb(1'b1, LNK, mw() & 32'hffff_dfff);
        chk({31'h0, ho_o}, 32'h1);
        attach <= 1'b0;
        repeat (6) @(posedge mclk);
        m_att = 0;
        m_chg = 1;
        m_dp = 0;
        m_dm = 0;
        rdc(LNK, mw());
        m_pwr = 0;
        apb(1'b1, LNK, mw() | 32'h0000_c000);
        rdc(LNK, mw());
        chk({30'h0, led}, 32'h0);
        $display("test handoff done");
        hc_reset <= 1'b1;
        @(posedge mclk);
        hc_reset <= 1'b0;
        @(posedge mclk);
        m_pic = 0;
        m_chg = 0;
        rdc(CAP, 32'h1);
        rdc(LNK, mw());
        $display("test host reset done");
        // Clock enable low: pins and bus frozen until it returns
        ce <= 1'b0;
        lines <= 2'h2;
        attach <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({31'h0, pready}, 32'h0);
        ce <= 1'b1;
        rdc(LNK, mw());
        m_dp = 1;
        rdc(LNK, mw());
        $display("test clock enable done");
        print_verdict();
    end
endmodule // lsc_link_ctrl_tb
